// [rtl/tone_fsk_regs.vh]
// register offsets, fields and timing constants of the tone and caller id block
`ifndef TONE_FSK_REGS_VH
`define TONE_FSK_REGS_VH
// register offsets
`define ADDR_T1_FREQ      5'h00
`define ADDR_T1_AMP       5'h01
`define ADDR_T1_PHASE     5'h02
`define ADDR_T1_ACTIVE    5'h03
`define ADDR_T1_INACTIVE  5'h04
`define ADDR_T2_FREQ      5'h05
`define ADDR_T2_AMP       5'h06
`define ADDR_T2_PHASE     5'h07
`define ADDR_T2_ACTIVE    5'h08
`define ADDR_T2_INACTIVE  5'h09
`define ADDR_CID_BYTE     5'h0a
`define ADDR_SPACE_FREQ   5'h0b
`define ADDR_MARK_FREQ    5'h0c
`define ADDR_SPACE_AMP    5'h0d
`define ADDR_MARK_AMP     5'h0e
`define ADDR_RISE_HI      5'h0f
`define ADDR_RISE_LO      5'h10
`define ADDR_FALL_HI      5'h11
`define ADDR_FALL_LO      5'h12
`define ADDR_OSC_CONTROL  5'h13
`define ADDR_OSC_MODE     5'h14
`define ADDR_IRQ_ENABLE   5'h15
`define ADDR_IRQ_VECTOR   5'h16
// osc control fields, generator 2 sits GEN2_SHIFT bits higher
`define CTL_OSC_ON        0
`define CTL_ACTIVE_EN     1
`define CTL_INACTIVE_EN   2
`define CTL_SIGNAL        3
`define CTL_ROUTE         4
`define CTL_GEN2_SHIFT    8
// osc mode fields
`define MODE_ZC1          0
`define MODE_ZC2          1
`define MODE_FSK_SEL      2
`define MODE_RAW8         3
`define MODE_BYTE_FULL    4
// interrupt fields
`define IRQ_G1_ACTIVE     0
`define IRQ_G1_INACTIVE   1
`define IRQ_G2_ACTIVE     2
`define IRQ_G2_INACTIVE   3
`define IRQ_FSK_BYTE      4
`define IRQ_BITS          5
// reset values
`define RST_WORD          16'h0000
// frame lengths
`define LEN_FRAMED        4'ha
`define LEN_RAW           4'h8
// timing
`define CLK_PERIOD_NS     10
`define TONE_STEP_NS      125000
`define FSK_STEP_NS       41660
`endif

// [rtl/cadence_timer.v]
// active / inactive cadence timer driving one oscillator enable bit
`timescale 1ns/1ns
module cadence_timer #(
   parameter CNT_W = 16
) (
   // clock and reset
   input  wire             clk_in,
   input  wire             nrst_in,
   // controls
   input  wire             tick_in,
   input  wire             sw_write_in,
   input  wire             sw_on_in,
   input  wire             active_en_in,
   input  wire             inactive_en_in,
   input  wire [CNT_W-1:0] active_time_in,
   input  wire [CNT_W-1:0] inactive_time_in,
   // state
   output reg              osc_on_out,
   output reg              active_done_out,
   output reg              inactive_done_out
);
   reg [CNT_W-1:0] count;

   always @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         count             <= {CNT_W{1'b0}};
         osc_on_out        <= 1'b0;
         active_done_out   <= 1'b0;
         inactive_done_out <= 1'b0;
      end else begin
         active_done_out   <= 1'b0;
         inactive_done_out <= 1'b0;
         if (sw_write_in) begin
            osc_on_out <= sw_on_in;
            count      <= {CNT_W{1'b0}};
         end else if (!active_en_in && !inactive_en_in) begin
            count <= {CNT_W{1'b0}};
         end else if (tick_in && osc_on_out && active_en_in) begin
            if (count >= active_time_in) begin
               count           <= {CNT_W{1'b0}};
               osc_on_out      <= 1'b0;
               active_done_out <= 1'b1;
            end else begin
               count <= count + 1'b1;
            end
         end else if (tick_in && !osc_on_out && active_en_in && inactive_en_in) begin
            if (count >= inactive_time_in) begin
               count             <= {CNT_W{1'b0}};
               osc_on_out        <= 1'b1;
               inactive_done_out <= 1'b1;
            end else begin
               count <= count + 1'b1;
            end
         end
      end
   end
endmodule

// [rtl/fsk_serializer.v]
// caller id byte serializer with optional start and stop framing
`timescale 1ns/1ns
`include "tone_fsk_regs.vh"
module fsk_serializer (
   // clock and reset
   input  wire        clk_in,
   input  wire        nrst_in,
   // controls
   input  wire        tick_in,
   input  wire        run_in,
   input  wire        raw8_in,
   input  wire [15:0] bit_time_in,
   input  wire        byte_full_in,
   input  wire [7:0]  byte_in,
   // stream
   output reg         take_out,
   output reg         bit_out
);
   reg [9:0]  shift;
   reg [3:0]  left;
   reg [15:0] count;
   wire       last_done;

   // last bit ends here, a waiting byte follows with no gap
   assign last_done = (left == 4'h1) && (count >= bit_time_in);

   always @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         shift    <= 10'h3ff;
         left     <= 4'h0;
         count    <= 16'h0000;
         take_out <= 1'b0;
         bit_out  <= 1'b1;
      end else begin
         take_out <= 1'b0;
         if (!run_in) begin
            left    <= 4'h0;
            count   <= 16'h0000;
            bit_out <= 1'b1;
         end else if (byte_full_in && tick_in && (left == 4'h0 || last_done)) begin
            count    <= 16'h0000;                                // frame starts on a tick
            take_out <= 1'b1;
            if (raw8_in) begin
               bit_out <= byte_in[0];
               shift   <= {3'b111, byte_in[7:1]};
               left    <= `LEN_RAW;
            end else begin
               bit_out <= 1'b0;
               shift   <= {1'b1, 1'b1, byte_in};
               left    <= `LEN_FRAMED;
            end
         end else if (left == 4'h0) begin
            count   <= 16'h0000;
            bit_out <= 1'b1;
         end else if (tick_in) begin
            if (count >= bit_time_in) begin
               count <= 16'h0000;
               left  <= left - 4'h1;
               if (left != 4'h1) begin
                  bit_out <= shift[0];
                  shift   <= {1'b1, shift[9:1]};
               end
            end else begin
               count <= count + 16'h0001;
            end
         end
      end
   end
endmodule

// [rtl/tone_cadence_fsk_caller_id.v]
// two cadenced tone generators with caller id fsk on generator 1
// Function
// - each generator owns an active timer and an inactive timer
// - output runs while active, suspended while inactive
// - both intervals count 125 us steps, 16 bits, up to about 8 s
// - one counter counts active, clears, counts inactive, alternating
// - with both timer enables set the timers drive the oscillator on bit
// - automatic cadence repeats until software clears the timer enables
// - zero cross stop makes each burst end on a waveform zero crossing
// - on bit plus active enable alone gives one single active burst
// - with both timer enables clear the on bit gates output directly
// - generator 2 behaves like generator 1 with its own bits
// - active and inactive expiry each raise an interrupt, own enable
// - pending bits per timer per generator read from interrupt vector
// - only generator 1 does fsk, with phase kept continuous
// - caller id byte is double buffered, interrupt as a byte starts
// - framing bit zero sends start and stop bits, one sends raw 8 bits
// - active timer sets the fsk bit period, byte rate is bit rate over 8 or 10
// - in fsk mode the active timer counts 41.66 us steps
// - zero bits use space coefficients, one bits use mark coefficients
// - transition coefficients apply at rising and falling bit edges
// - tone samples are computed at 8000 Hz
// - fsk coefficients are used at a 24000 Hz sample rate
//
// Our own choices: the register addresses and strobed register access.
`timescale 1ns/1ns
`include "tone_fsk_regs.vh"
module tone_cadence_fsk_caller_id #(
   parameter TONE_STEP_CYCLES = `TONE_STEP_NS / `CLK_PERIOD_NS,
   parameter FSK_STEP_CYCLES  = `FSK_STEP_NS / `CLK_PERIOD_NS
) (
   // clock and reset
   input  wire        clk_in,
   input  wire        nrst_in,
   // register port
   input  wire [4:0]  addr_in,
   input  wire [15:0] wr_data_in,
   input  wire        wr_in,
   input  wire        rd_in,
   output reg  [15:0] rd_data_out,
   // generator 1 audio
   output reg         gen1_active_out,
   output reg         gen1_path_route_out,
   output reg  [15:0] gen1_freq_out,
   output reg  [15:0] gen1_amp_out,
   output reg  [15:0] gen1_phase_out,
   output reg         fsk_bit_out,
   // generator 2 audio
   output reg         gen2_active_out,
   output reg         gen2_path_route_out,
   output reg  [15:0] gen2_freq_out,
   output reg  [15:0] gen2_amp_out,
   output reg  [15:0] gen2_phase_out
);
   localparam integer TONE_END  = TONE_STEP_CYCLES - 1;
   localparam integer FSK_END   = FSK_STEP_CYCLES - 1;
   localparam [13:0]  TONE_LAST = TONE_END[13:0];
   localparam [13:0]  FSK_LAST  = FSK_END[13:0];

   // only bits 15:3 of a frequency or fsk coefficient are significant
   function [15:0] coeff;
      input [15:0] value;
      begin
         coeff = {value[15:3], 3'b000};
      end
   endfunction

   // sign change of the phase marks a zero crossing
   function crossing;
      input [15:0] old_phase;
      input [15:0] new_phase;
      begin
         crossing = old_phase[15] ^ new_phase[15];
      end
   endfunction

   // coefficient store
   reg  [15:0] freq_c     [0:1];
   reg  [15:0] amp_c      [0:1];
   reg  [15:0] phase_c    [0:1];
   reg  [15:0] active_t   [0:1];
   reg  [15:0] inactive_t [0:1];
   reg  [15:0] space_freq;
   reg  [15:0] mark_freq;
   reg  [15:0] space_amp;
   reg  [15:0] mark_amp;
   reg  [15:0] rise_hi;
   reg  [15:0] rise_lo;
   reg  [15:0] fall_hi;
   reg  [15:0] fall_lo;
   reg  [7:0]  callerid_byte;
   reg         byte_full;
   // control
   reg  [1:0]  active_en;
   reg  [1:0]  inactive_en;
   reg  [1:0]  route;
   reg  [1:0]  zc_en;
   reg         fsk_sel;
   reg         raw8;
   reg  [`IRQ_BITS-1:0] irq_en;
   reg  [`IRQ_BITS-1:0] irq_vec;
   // timebase
   reg  [13:0] tone_div;
   reg  [13:0] fsk_div;
   reg         tone_tick;
   reg         fsk_tick;
   // generator state
   reg  [15:0] phase      [0:1];
   reg  [1:0]  gate;
   reg         prev_bit;
   reg  [1:0]  edge_kind;
   wire [1:0]  osc_on;
   wire [1:0]  a_done;
   wire [1:0]  i_done;
   wire [1:0]  ctl_write;
   wire        fsk_take;
   wire        fsk_bit;
   wire        fsk_run;
   wire [15:0] fsk_inc;
   wire [15:0] ctl_word;
   reg  [15:0] next_phase [0:1];
   reg  [1:0]  gen_tick;
   reg  [`IRQ_BITS-1:0] next_irq;
   integer     k, j;

   assign ctl_write[0] = wr_in && (addr_in == `ADDR_OSC_CONTROL);
   assign ctl_write[1] = ctl_write[0];
   assign fsk_run      = fsk_sel && osc_on[0];
   assign fsk_inc      = fsk_bit ? coeff(mark_freq) : coeff(space_freq);
   assign ctl_word     = {3'b000, route[1], gen2_active_out, inactive_en[1], active_en[1],
                          osc_on[1], 3'b000, route[0], gen1_active_out, inactive_en[0],
                          active_en[0], osc_on[0]};

   // 8 kHz tone tick and 24 kHz fsk tick
   always @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         tone_div  <= 14'h0000;
         fsk_div   <= 14'h0000;
         tone_tick <= 1'b0;
         fsk_tick  <= 1'b0;
      end else begin
         tone_tick <= (tone_div == TONE_LAST);
         tone_div  <= (tone_div == TONE_LAST) ? 14'h0000 : tone_div + 14'h0001;
         fsk_tick  <= (fsk_div == FSK_LAST);
         fsk_div   <= (fsk_div == FSK_LAST) ? 14'h0000 : fsk_div + 14'h0001;
      end
   end

   // one cadence timer per generator
   genvar g;
   generate
      for (g = 0; g < 2; g = g + 1) begin : gen_cad
         cadence_timer #(
            .CNT_W            (16)
         ) u_cad (
            .clk_in           (clk_in),
            .nrst_in          (nrst_in),
            .tick_in          (tone_tick),
            .sw_write_in      (ctl_write[g]),
            .sw_on_in         (wr_data_in[`CTL_OSC_ON + g * `CTL_GEN2_SHIFT]),
            .active_en_in     (active_en[g] && !(g == 0 && fsk_sel)),
            .inactive_en_in   (inactive_en[g] && !(g == 0 && fsk_sel)),
            .active_time_in   (active_t[g]),
            .inactive_time_in (inactive_t[g]),
            .osc_on_out       (osc_on[g]),
            .active_done_out  (a_done[g]),
            .inactive_done_out(i_done[g])
         );
      end
   endgenerate

   fsk_serializer u_fsk (
      .clk_in      (clk_in),
      .nrst_in     (nrst_in),
      .tick_in     (fsk_tick),
      .run_in      (fsk_run),
      .raw8_in     (raw8),
      .bit_time_in (active_t[0]),
      .byte_full_in(byte_full),
      .byte_in     (callerid_byte),
      .take_out    (fsk_take),
      .bit_out     (fsk_bit)
   );

   // phase stepping and pending bits
   always @* begin
      gen_tick[0] = fsk_sel ? fsk_tick : tone_tick;
      gen_tick[1] = tone_tick;
      next_phase[0] = phase[0] + (fsk_sel ? fsk_inc : coeff(freq_c[0]));
      next_phase[1] = phase[1] + coeff(freq_c[1]);
      next_irq = irq_vec;
      if (wr_in && addr_in == `ADDR_IRQ_VECTOR) begin
         next_irq = irq_vec & ~wr_data_in[`IRQ_BITS-1:0];
      end
      next_irq = next_irq | (irq_en & {fsk_take, i_done[1], a_done[1], i_done[0], a_done[0]});
   end

   // register writes
   always @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         for (k = 0; k < 2; k = k + 1) begin
            freq_c[k]     <= `RST_WORD;
            amp_c[k]      <= `RST_WORD;
            phase_c[k]    <= `RST_WORD;
            active_t[k]   <= `RST_WORD;
            inactive_t[k] <= `RST_WORD;
         end
         space_freq    <= `RST_WORD;
         mark_freq     <= `RST_WORD;
         space_amp     <= `RST_WORD;
         mark_amp      <= `RST_WORD;
         rise_hi       <= `RST_WORD;
         rise_lo       <= `RST_WORD;
         fall_hi       <= `RST_WORD;
         fall_lo       <= `RST_WORD;
         callerid_byte <= 8'h00;
         byte_full     <= 1'b0;
         active_en     <= 2'b00;
         inactive_en   <= 2'b00;
         route         <= 2'b00;
         zc_en         <= 2'b00;
         fsk_sel       <= 1'b0;
         raw8          <= 1'b0;
         irq_en        <= {`IRQ_BITS{1'b0}};
         irq_vec       <= {`IRQ_BITS{1'b0}};
      end else begin
         irq_vec <= next_irq;
         if (fsk_take) begin
            byte_full <= 1'b0;
         end
         if (wr_in) begin
            case (addr_in)
               `ADDR_T1_FREQ:     freq_c[0]     <= wr_data_in;
               `ADDR_T1_AMP:      amp_c[0]      <= wr_data_in;
               `ADDR_T1_PHASE:    phase_c[0]    <= wr_data_in;
               `ADDR_T1_ACTIVE:   active_t[0]   <= wr_data_in;
               `ADDR_T1_INACTIVE: inactive_t[0] <= wr_data_in;
               `ADDR_T2_FREQ:     freq_c[1]     <= wr_data_in;
               `ADDR_T2_AMP:      amp_c[1]      <= wr_data_in;
               `ADDR_T2_PHASE:    phase_c[1]    <= wr_data_in;
               `ADDR_T2_ACTIVE:   active_t[1]   <= wr_data_in;
               `ADDR_T2_INACTIVE: inactive_t[1] <= wr_data_in;
               `ADDR_CID_BYTE: begin
                  callerid_byte <= wr_data_in[7:0];
                  byte_full     <= 1'b1;
               end
               `ADDR_SPACE_FREQ:  space_freq <= wr_data_in;
               `ADDR_MARK_FREQ:   mark_freq  <= wr_data_in;
               `ADDR_SPACE_AMP:   space_amp  <= wr_data_in;
               `ADDR_MARK_AMP:    mark_amp   <= wr_data_in;
               `ADDR_RISE_HI:     rise_hi    <= wr_data_in;
               `ADDR_RISE_LO:     rise_lo    <= wr_data_in;
               `ADDR_FALL_HI:     fall_hi    <= wr_data_in;
               `ADDR_FALL_LO:     fall_lo    <= wr_data_in;
               `ADDR_OSC_CONTROL: begin
                  active_en   <= {wr_data_in[`CTL_ACTIVE_EN + `CTL_GEN2_SHIFT],
                                  wr_data_in[`CTL_ACTIVE_EN]};
                  inactive_en <= {wr_data_in[`CTL_INACTIVE_EN + `CTL_GEN2_SHIFT],
                                  wr_data_in[`CTL_INACTIVE_EN]};
                  route       <= {wr_data_in[`CTL_ROUTE + `CTL_GEN2_SHIFT],
                                  wr_data_in[`CTL_ROUTE]};
               end
               `ADDR_OSC_MODE: begin
                  zc_en   <= {wr_data_in[`MODE_ZC2], wr_data_in[`MODE_ZC1]};
                  fsk_sel <= wr_data_in[`MODE_FSK_SEL];
                  raw8    <= wr_data_in[`MODE_RAW8];
               end
               `ADDR_IRQ_ENABLE:  irq_en <= wr_data_in[`IRQ_BITS-1:0];
               default: begin
               end
            endcase
         end
      end
   end

   // burst gating with optional zero crossing stop
   always @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         phase[0] <= `RST_WORD;
         phase[1] <= `RST_WORD;
         gate     <= 2'b00;
      end else begin
         for (j = 0; j < 2; j = j + 1) begin
            if (osc_on[j] && !gate[j]) begin
               gate[j]  <= 1'b1;
               phase[j] <= phase_c[j];
            end else if (gate[j] && gen_tick[j]) begin
               phase[j] <= next_phase[j];
               if (!osc_on[j] && crossing(phase[j], next_phase[j])) begin
                  gate[j] <= 1'b0;
               end
            end
            if (!osc_on[j] && !zc_en[j]) begin
               gate[j] <= 1'b0;
            end
         end
      end
   end

   // fsk bit edge tracking
   always @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         prev_bit  <= 1'b1;
         edge_kind <= 2'b00;
      end else if (fsk_tick) begin
         prev_bit  <= fsk_bit;
         edge_kind <= {prev_bit & ~fsk_bit, ~prev_bit & fsk_bit};
      end
   end

   // audio side outputs
   always @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         gen1_active_out     <= 1'b0;
         gen2_active_out     <= 1'b0;
         gen1_path_route_out <= 1'b0;
         gen2_path_route_out <= 1'b0;
         gen1_freq_out       <= `RST_WORD;
         gen1_amp_out        <= `RST_WORD;
         gen1_phase_out      <= `RST_WORD;
         gen2_freq_out       <= `RST_WORD;
         gen2_amp_out        <= `RST_WORD;
         gen2_phase_out      <= `RST_WORD;
         fsk_bit_out         <= 1'b1;
      end else begin
         gen1_active_out     <= gate[0];
         gen2_active_out     <= gate[1];
         gen1_path_route_out <= route[0];
         gen2_path_route_out <= route[1];
         gen1_phase_out      <= phase[0];
         gen2_phase_out      <= phase[1];
         gen2_freq_out       <= coeff(freq_c[1]);
         gen2_amp_out        <= amp_c[1];
         fsk_bit_out         <= fsk_sel ? fsk_bit : 1'b1;
         if (fsk_sel && edge_kind[0]) begin
            gen1_freq_out <= coeff(rise_hi);
            gen1_amp_out  <= coeff(rise_lo);
         end else if (fsk_sel && edge_kind[1]) begin
            gen1_freq_out <= coeff(fall_hi);
            gen1_amp_out  <= coeff(fall_lo);
         end else if (fsk_sel) begin
            gen1_freq_out <= fsk_inc;
            gen1_amp_out  <= fsk_bit ? coeff(mark_amp) : coeff(space_amp);
         end else begin
            gen1_freq_out <= coeff(freq_c[0]);
            gen1_amp_out  <= amp_c[0];
         end
      end
   end

   // register reads, unmapped reads return zero
   always @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         rd_data_out <= `RST_WORD;
      end else if (rd_in) begin
         case (addr_in)
            `ADDR_T1_FREQ:     rd_data_out <= freq_c[0];
            `ADDR_T1_AMP:      rd_data_out <= amp_c[0];
            `ADDR_T1_PHASE:    rd_data_out <= phase_c[0];
            `ADDR_T1_ACTIVE:   rd_data_out <= active_t[0];
            `ADDR_T1_INACTIVE: rd_data_out <= inactive_t[0];
            `ADDR_T2_FREQ:     rd_data_out <= freq_c[1];
            `ADDR_T2_AMP:      rd_data_out <= amp_c[1];
            `ADDR_T2_PHASE:    rd_data_out <= phase_c[1];
            `ADDR_T2_ACTIVE:   rd_data_out <= active_t[1];
            `ADDR_T2_INACTIVE: rd_data_out <= inactive_t[1];
            `ADDR_CID_BYTE:    rd_data_out <= {8'h00, callerid_byte};
            `ADDR_SPACE_FREQ:  rd_data_out <= space_freq;
            `ADDR_MARK_FREQ:   rd_data_out <= mark_freq;
            `ADDR_SPACE_AMP:   rd_data_out <= space_amp;
            `ADDR_MARK_AMP:    rd_data_out <= mark_amp;
            `ADDR_RISE_HI:     rd_data_out <= rise_hi;
            `ADDR_RISE_LO:     rd_data_out <= rise_lo;
            `ADDR_FALL_HI:     rd_data_out <= fall_hi;
            `ADDR_FALL_LO:     rd_data_out <= fall_lo;
            `ADDR_OSC_CONTROL: rd_data_out <= ctl_word;
            `ADDR_OSC_MODE:    rd_data_out <= {11'h000, byte_full, raw8, fsk_sel, zc_en};
            `ADDR_IRQ_ENABLE:  rd_data_out <= {11'h000, irq_en};
            `ADDR_IRQ_VECTOR:  rd_data_out <= {11'h000, irq_vec};
            default:           rd_data_out <= `RST_WORD;
         endcase
      end else begin
         rd_data_out <= `RST_WORD;
      end
   end
endmodule

// [verif/tone_fsk_props.sv]
// assertion checker of the tone and caller id block
`timescale 1ns/1ns
module tone_fsk_props #(
   parameter FSK_STEP_CYCLES = 4
) (
   // clock, reset, register port
   input wire        clk_in,
   input wire        nrst_in,
   input wire [4:0]  addr_in,
   input wire [15:0] wr_data_in,
   input wire        wr_in,
   input wire        rd_in,
   input wire [15:0] rd_data_out,
   // generator outputs
   input wire        gen1_active_out,
   input wire        gen1_path_route_out,
   input wire [15:0] gen1_freq_out,
   input wire        fsk_bit_out,
   input wire        gen2_active_out,
   input wire        gen2_path_route_out,
   input wire [15:0] gen2_freq_out
);
   default clocking @(posedge clk_in); endclocking
   default disable iff (!nrst_in);
   wire ctl_wr = wr_in && addr_in == 5'h13;
   a_rd_quiet: assert property (!$past(rd_in) |-> rd_data_out == 16'h0000)
      else $error("read data outside slot");
   a_vec_width: assert property ($past(rd_in && addr_in == 5'h16) |-> rd_data_out[15:5] == 11'h0)
      else $error("vector upper bits set");
   a_g1_freq_mask: assert property (gen1_freq_out[2:0] == 3'h0)
      else $error("gen1 freq low bits");
   a_g2_freq_mask: assert property (gen2_freq_out[2:0] == 3'h0)
      else $error("gen2 freq low bits");
   a_fsk_bit_min: assert property ($changed(fsk_bit_out) |=> $stable(fsk_bit_out)[*3])
      else $error("fsk bit too short");
   a_g1_direct_on: assert property (ctl_wr && wr_data_in[2:0] == 3'h1 ##1 (!wr_in)[*2] |=> gen1_active_out)
      else $error("gen1 not on");
   a_g2_direct_on: assert property (ctl_wr && wr_data_in[10:8] == 3'h1 ##1 (!wr_in)[*2] |=> gen2_active_out)
      else $error("gen2 not on");
   a_g2_route: assert property (ctl_wr ##1 !wr_in |=> gen2_path_route_out == $past(wr_data_in[12], 2))
      else $error("gen2 route wrong");
   a_g1_route: assert property (ctl_wr ##1 !wr_in |=> gen1_path_route_out == $past(wr_data_in[4], 2))
      else $error("gen1 route wrong");
   cover property ($rose(gen1_active_out));
   cover property ($fell(fsk_bit_out));
   cover property (rd_in && addr_in == 5'h16);
endmodule
bind tone_cadence_fsk_caller_id tone_fsk_props #(.FSK_STEP_CYCLES(FSK_STEP_CYCLES)) props (.*);

// [verif/audio_sink.sv]
// audio path model timing generator 1 bursts
`timescale 1ns/1ns
module audio_sink (
   // clock and gate
   input  wire        clk_in,
   input  wire        active_in,
   // last burst length in clocks
   output reg  [15:0] burst_out = 16'h0000
);
   reg [15:0] run = 16'h0000;
   always @(posedge clk_in) begin
      run <= active_in ? run + 16'h0001 : 16'h0000;
      if (!active_in && run != 16'h0000)
         burst_out <= run;
   end
endmodule

// [verif/tone_cadence_fsk_caller_id_tb_top.sv]
// self-checking bench of the tone and caller id block
`timescale 1ns/1ns
`include "tone_fsk_regs.vh"
module tone_cadence_fsk_caller_id_tb_top;
   reg         clk_in, nrst_in, wr_in, rd_in;
   reg  [4:0]  addr_in;
   reg  [15:0] wr_data_in;
   wire [15:0] rd_data_out, burst, a1, p2;
   wire        g1_on, g2_on, fsk_bit;
   reg  [36:0] rows [0:5];
   integer     mismatches, num_checks, i;
   tone_cadence_fsk_caller_id #(.TONE_STEP_CYCLES(8), .FSK_STEP_CYCLES(4)) dut (
      .clk_in(clk_in), .nrst_in(nrst_in), .addr_in(addr_in), .wr_data_in(wr_data_in),
      .wr_in(wr_in), .rd_in(rd_in), .rd_data_out(rd_data_out), .gen1_active_out(g1_on),
      .gen1_path_route_out(), .gen1_freq_out(), .gen1_amp_out(a1), .gen1_phase_out(),
      .fsk_bit_out(fsk_bit), .gen2_active_out(g2_on), .gen2_path_route_out(),
      .gen2_freq_out(), .gen2_amp_out(), .gen2_phase_out(p2));
   audio_sink sink (.clk_in(clk_in), .active_in(g1_on), .burst_out(burst));
   task chk(input [15:0] got, input [15:0] exp);
      begin
         num_checks = num_checks + 1;
         if (got !== exp) begin
            mismatches = mismatches + 1;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
         end
      end
   endtask
   task wr(input [4:0] a, input [15:0] d);
      begin
         addr_in <= a;
         wr_data_in <= d;
         wr_in <= 1'b1;
         @(posedge clk_in);
         wr_in <= 1'b0;
         @(posedge clk_in);
      end
   endtask
   task rdc(input [4:0] a, input [15:0] exp);
      begin
         addr_in <= a;
         rd_in <= 1'b1;
         @(posedge clk_in);
         rd_in <= 1'b0;
         @(posedge clk_in);
         chk(rd_data_out, exp);
      end
   endtask
   task fsk(input [15:0] mode, input [7:0] b, input [9:0] pat);
      integer k;
      begin
         wr(`ADDR_OSC_MODE, mode);
         wr(`ADDR_CID_BYTE, {8'h00, b});
         k = 0;
         while (fsk_bit !== 1'b0 && k < 20) begin
            @(posedge clk_in);
            k = k + 1;
         end
         repeat (2) @(posedge clk_in);
         for (k = 0; k < 10; k = k + 1) begin
            chk({15'h0, fsk_bit}, {15'h0, pat[k]});
            repeat (4) @(posedge clk_in);
         end
      end
   endtask
   task wrap_up;
      begin
         $display("checks=%0d mismatches=%0d", num_checks, mismatches);
         if (mismatches == 0 && num_checks > 0)
            $display("[ PASS ]");
         else
            $display("[ FAIL ]");
         $finish;
      end
   endtask
   initial begin
      clk_in = 1'b0;
      forever #5 clk_in = ~clk_in;
   end
   initial begin
      #100000;
      mismatches = mismatches + 1;
      wrap_up;
   end
   initial begin
      {nrst_in, wr_in, rd_in, addr_in, wr_data_in} = 0;
      mismatches = 0;
      num_checks = 0;
      rows[0] = {5'h01, 16'ha5c3, 16'ha5c3};
      rows[1] = {5'h07, 16'h5a3c, 16'h5a3c};
      rows[2] = {5'h0e, 16'hffff, 16'hffff};
      rows[3] = {5'h12, 16'h0f0f, 16'h0f0f};
      rows[4] = {5'h1f, 16'habcd, 16'h0000};
      rows[5] = {5'h15, 16'h001f, 16'h001f};
      repeat (4) @(posedge clk_in);
      nrst_in <= 1'b1;
      rdc(`ADDR_T1_PHASE, `RST_WORD);
      for (i = 0; i < 6; i = i + 1) begin
         wr(rows[i][36:32], rows[i][31:16]);
         rdc(rows[i][36:32], rows[i][15:0]);
      end
      wr(`ADDR_OSC_CONTROL, 16'h1101);
      repeat (2) @(posedge clk_in);
      chk({14'h0, g2_on, g1_on}, 16'h0003);
      chk(a1, 16'ha5c3);
      chk(p2, 16'h5a3c);
      wr(`ADDR_OSC_CONTROL, 16'h0000);
      repeat (4) @(posedge clk_in);
      chk({14'h0, g2_on, g1_on}, 16'h0000);
      wr(`ADDR_T1_ACTIVE, 16'h0002);
      wr(`ADDR_T1_INACTIVE, 16'h0001);
      wr(`ADDR_OSC_CONTROL, 16'h0007);
      repeat (100) @(posedge clk_in);
      chk(burst, 16'h0018);
      rdc(`ADDR_IRQ_VECTOR, 16'h0003);
      wr(`ADDR_OSC_CONTROL, 16'h0000);
      wr(`ADDR_IRQ_VECTOR, 16'h001f);
      repeat (50) @(posedge clk_in);
      rdc(`ADDR_IRQ_VECTOR, 16'h0000);
      wr(`ADDR_OSC_CONTROL, 16'h0003);
      repeat (60) @(posedge clk_in);
      chk({15'h0, g1_on}, 16'h0000);
      rdc(`ADDR_IRQ_VECTOR, 16'h0001);
      wr(`ADDR_IRQ_VECTOR, 16'h001f);
      wr(`ADDR_T1_ACTIVE, 16'h0000);
      wr(`ADDR_OSC_CONTROL, 16'h0001);
      fsk(16'h0004, 8'ha5, {1'b1, 8'ha5, 1'b0});
      rdc(`ADDR_IRQ_VECTOR, 16'h0010);
      fsk(16'h000c, 8'h5a, {2'b11, 8'h5a});
      wrap_up;
   end
endmodule
